//--- src/mrb_reg_bits.sv
// Bit behaviour core for the management register set
`timescale 1ns/1ps
// What this block does
// - Reset loads every defined default value
// - Strap bits take pin level at reset
// - High bit captures event, holds until read
// - After read, high bit reloads present level
// - Low bit captures low event, holds zero
// - After read, low bit reloads present level
// - Max group keeps largest unsigned value seen
// - Max group held until reset or read
// - After read, max group loads present state
// - Trigger bits reset zero; one starts function
// - Trigger bit self-clears when function finishes
// - Protected bits writable only after override write
// - Low-power entry defaults only high and low latch bits
module mrb_reg_bits
    import mrb_pkg::*;
#(
    parameter int NH = NUM_HIGH,
    parameter int NL = NUM_LOW,
    parameter int MW = MAX_WIDTH,
    parameter int NT = NUM_TRIG,
    parameter int NP = NUM_PROT,
    parameter int NR = NUM_RW
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Strap pins, sampled while reset is held
    input wire logic [NUM_STRAP-1:0] strapPins,
    // Monitored signals
    input wire logic [NH-1:0] highEvent,
    input wire logic [NL-1:0] lowEventN,
    input wire logic [MW-1:0] smState,
    input wire logic [NT-1:0] trigDone,
    // Management access strobes
    input wire logic rdHigh,
    input wire logic rdLow,
    input wire logic rdMax,
    input wire logic wrStb,
    input wire logic wrOverride,
    input wire logic [NT-1:0] wrTrig,
    input wire logic [NP-1:0] wrProtData,
    input wire logic [NR-1:0] wrRwData,
    input wire logic wrLowPwr,
    // Register bit values
    output logic [NUM_STRAP-1:0] strapAddr_r,
    output logic [NH-1:0] latchHighBit_r,
    output logic [NL-1:0] latchLowBit_r,
    output logic [MW-1:0] latchMaxGroup_r,
    output logic [NT-1:0] selfClearBit_r,
    output logic [NT-1:0] trigStart_r,
    output logic overrideWriteBit_r,
    output logic [NP-1:0] protBits_r,
    output logic [NR-1:0] rwBits_r,
    output logic lowPower_r
);
    logic [NUM_STRAP-1:0] strapAddr_nxt;
    logic [NH-1:0] latchHighBit_nxt;
    logic [NL-1:0] latchLowBit_nxt;
    logic [MW-1:0] latchMaxGroup_nxt;
    logic [NT-1:0] selfClearBit_nxt;
    logic [NT-1:0] trigStart_nxt;
    logic overrideWriteBit_nxt;
    logic [NP-1:0] protBits_nxt;
    logic [NR-1:0] rwBits_nxt;
    logic lowPower_nxt;
    logic lowPwrEntry;
    mrb_trig_t trigState_r [NT];
    mrb_trig_t trigState_nxt [NT];

    // Unsigned compare from MSB down
    function automatic logic isLarger(input logic [MW-1:0] a,
                                      input logic [MW-1:0] b);
        isLarger = a > b;
    endfunction

    // Only the rising edge of the power-down bit clears latches
    assign lowPwrEntry = wrStb && wrLowPwr && !lowPower_r;

    always_comb begin
        strapAddr_nxt = strapAddr_r;
        if (sys_rst) begin
            strapAddr_nxt = strapPins;
        end
    end

    // Latching status bits
    always_comb begin
        latchHighBit_nxt = latchHighBit_r;
        latchLowBit_nxt = latchLowBit_r;
        latchMaxGroup_nxt = latchMaxGroup_r;
        if (lowPwrEntry) begin
            latchHighBit_nxt = HIGH_RST;
            latchLowBit_nxt = LOW_RST;
        end else begin
            // Reload present level; it already includes any event now
            if (rdHigh) begin
                latchHighBit_nxt = highEvent;
            end else begin
                latchHighBit_nxt = latchHighBit_r | highEvent;
            end
            if (rdLow) begin
                latchLowBit_nxt = lowEventN;
            end else begin
                latchLowBit_nxt = latchLowBit_r & lowEventN;
            end
        end
        // Max group ignores low-power entry
        if (rdMax) begin
            latchMaxGroup_nxt = smState;
        end else if (isLarger(smState, latchMaxGroup_r)) begin
            latchMaxGroup_nxt = smState;
        end
    end

    // Writable bits and override
    always_comb begin
        protBits_nxt = protBits_r;
        rwBits_nxt = rwBits_r;
        overrideWriteBit_nxt = overrideWriteBit_r;
        lowPower_nxt = lowPower_r;
        if (wrStb) begin
            // Single register model: every write lands in all plain bits
            rwBits_nxt = wrRwData;
            lowPower_nxt = wrLowPwr;
            if (overrideWriteBit_r) begin
                protBits_nxt = wrProtData;
            end
            // The write that sets override is itself unprotected
            overrideWriteBit_nxt = wrOverride;
        end
    end

    // Self-clearing trigger bits
    always_comb begin
        selfClearBit_nxt = selfClearBit_r;
        trigStart_nxt = '0;
        for (int i = 0; i < NT; i++) begin
            trigState_nxt[i] = trigState_r[i];
            unique case (trigState_r[i])
                MRB_IDLE: begin
                    if (wrStb && wrTrig[i]) begin
                        trigState_nxt[i] = MRB_RUN;
                        selfClearBit_nxt[i] = 1'h1;
                        trigStart_nxt[i] = 1'b1;
                    end
                end
                MRB_RUN: begin
                    // A start while busy is dropped, not queued
                    if (trigDone[i]) begin
                        trigState_nxt[i] = MRB_IDLE;
                        selfClearBit_nxt[i] = 1'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        strapAddr_r <= strapAddr_nxt;
    end

    // Latch registers; reset loads the defined defaults
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            latchHighBit_r <= HIGH_RST;
            latchLowBit_r <= LOW_RST;
            latchMaxGroup_r <= MAX_RST;
        end else begin
            latchHighBit_r <= latchHighBit_nxt;
            latchLowBit_r <= latchLowBit_nxt;
            latchMaxGroup_r <= latchMaxGroup_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            overrideWriteBit_r <= OVR_RST;
            protBits_r <= PROT_RST;
            rwBits_r <= RW_RST;
            lowPower_r <= LOWPWR_RST;
        end else begin
            overrideWriteBit_r <= overrideWriteBit_nxt;
            protBits_r <= protBits_nxt;
            rwBits_r <= rwBits_nxt;
            lowPower_r <= lowPower_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            selfClearBit_r <= TRIG_RST;
            trigStart_r <= TRIG_RST;
            for (int i = 0; i < NT; i++) begin
                trigState_r[i] <= MRB_IDLE;
            end
        end else begin
            selfClearBit_r <= selfClearBit_nxt;
            trigStart_r <= trigStart_nxt;
            for (int i = 0; i < NT; i++) begin
                trigState_r[i] <= trigState_nxt[i];
            end
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    highHold_a: assert property (
        latchHighBit_r[0] && !rdHigh && !lowPwrEntry |=> latchHighBit_r[0])
        else $error("high latch lost its event");
    highCatch_a: assert property (
        highEvent[0] && !lowPwrEntry |=> latchHighBit_r[0])
        else $error("high event not captured");
    highReload_a: assert property (
        rdHigh && !lowPwrEntry |=> latchHighBit_r == $past(highEvent))
        else $error("high latch not reloaded after read");
    lowHold_a: assert property (
        !latchLowBit_r[0] && !rdLow && !lowPwrEntry |=> !latchLowBit_r[0])
        else $error("low latch lost its event");
    lowReload_a: assert property (
        rdLow && !lowPwrEntry |=> latchLowBit_r == $past(lowEventN))
        else $error("low latch not reloaded after read");
    maxKeep_a: assert property (
        !rdMax |=> latchMaxGroup_r >= $past(latchMaxGroup_r) &&
        latchMaxGroup_r >= $past(smState))
        else $error("max group dropped below maximum");
    maxReload_a: assert property (
        rdMax |=> latchMaxGroup_r == $past(smState))
        else $error("max group not loaded after read");
    trigClear_a: assert property (
        selfClearBit_r[0] && trigDone[0] |=> !selfClearBit_r[0])
        else $error("trigger bit did not self-clear");
    trigSet_a: assert property (
        !selfClearBit_r[0] && wrStb && wrTrig[0] |=>
        selfClearBit_r[0] && trigStart_r[0] ##1 !trigStart_r[0])
        else $error("trigger write did not start function");
    protGuard_a: assert property (
        wrStb && !overrideWriteBit_r |=> $stable(protBits_r))
        else $error("protected bits changed without override");
    ovrOnce_a: assert property (
        wrStb && overrideWriteBit_r && !wrOverride |=> !overrideWriteBit_r)
        else $error("override did not clear on write");
    lpEntry_a: assert property (
        lowPwrEntry |=> latchHighBit_r == HIGH_RST &&
        latchLowBit_r == LOW_RST && rwBits_r == $past(wrRwData))
        else $error("low-power entry handled latches wrongly");
    highLpKeep_a: assert property (
        lowPower_r && !rdHigh |=>
        (latchHighBit_r & $past(latchHighBit_r)) == $past(latchHighBit_r))
        else $error("high latches lost while already in low power");
    lowLpKeep_a: assert property (
        lowPower_r && !rdLow |=>
        (latchLowBit_r | $past(latchLowBit_r)) == $past(latchLowBit_r))
        else $error("low latches lost while already in low power");
    lpWrite_a: assert property (
        wrStb |=> lowPower_r == $past(wrLowPwr))
        else $error("low-power bit not written");
    lowCatch_a: assert property (
        !lowEventN[0] && !lowPwrEntry |=> !latchLowBit_r[0])
        else $error("low event not captured");
    maxHold_a: assert property (
        !rdMax && !isLarger(smState, latchMaxGroup_r) |=>
        $stable(latchMaxGroup_r))
        else $error("max group changed without larger state");
    protWrite_a: assert property (
        wrStb && overrideWriteBit_r |=> protBits_r == $past(wrProtData))
        else $error("override write not applied to protected bits");
    trigBusy_a: assert property (
        selfClearBit_r[0] && !trigDone[0] |=>
        selfClearBit_r[0] && !trigStart_r[0])
        else $error("trigger bit cleared before function finished");
    trigIdle_a: assert property (
        trigStart_r[0] |-> selfClearBit_r[0])
        else $error("start pulse without trigger bit set");

    // Reset defaults, checked with the default disable lifted
    rstLoad_a: assert property (
        disable iff (1'h0) sys_rst |=> latchHighBit_r == HIGH_RST &&
        latchLowBit_r == LOW_RST && latchMaxGroup_r == MAX_RST)
        else $error("latch defaults not loaded by reset");
    rstCtrl_a: assert property (
        disable iff (1'h0) sys_rst |=> selfClearBit_r == TRIG_RST &&
        overrideWriteBit_r == OVR_RST && protBits_r == PROT_RST)
        else $error("control defaults not loaded by reset");
    strapLoad_a: assert property (
        disable iff (1'h0) sys_rst |=> strapAddr_r == $past(strapPins))
        else $error("strap value not taken at reset");
    strapKeep_a: assert property (
        !sys_rst |=> $stable(strapAddr_r))
        else $error("strap value changed outside reset");

    highEventCov: cover property (highEvent[0] ##1 !highEvent[0] ##1 rdHigh);
    maxGrowCov: cover property (isLarger(smState, latchMaxGroup_r) ##1 rdMax);
    trigRunCov: cover property (wrStb && wrTrig[0] ##[1:20] trigDone[0]);
    protWriteCov: cover property (wrStb && overrideWriteBit_r);
    lpHoldCov: cover property (lowPower_r && wrStb && wrLowPwr);
endmodule

//--- common/mrb_pkg.sv
// Shared constants for the management register bit behaviour bank
package mrb_pkg;
    localparam int NUM_HIGH = 4;
    localparam int NUM_LOW = 4;
    localparam int MAX_WIDTH = 3;
    localparam int NUM_TRIG = 2;
    localparam int NUM_PROT = 8;
    localparam int NUM_RW = 8;
    localparam int NUM_STRAP = 5;
    localparam logic [NUM_HIGH-1:0] HIGH_RST = 4'h0;
    localparam logic [NUM_LOW-1:0] LOW_RST = 4'hF;
    localparam logic [MAX_WIDTH-1:0] MAX_RST = 3'h0;
    localparam logic [NUM_TRIG-1:0] TRIG_RST = 2'h0;
    localparam logic [NUM_PROT-1:0] PROT_RST = 8'h00;
    localparam logic [NUM_RW-1:0] RW_RST = 8'h00;
    localparam logic OVR_RST = 1'h0;
    localparam logic LOWPWR_RST = 1'h0;
    typedef enum logic [1:0] {
        MRB_IDLE,
        MRB_RUN
    } mrb_trig_t;
endpackage

//--- verif/mrb_func_model.sv
// Model of the function engine behind the self-clearing trigger bits
`timescale 1ns/1ps
module mrb_func_model #(
    parameter int NT = 2,
    parameter int DLY = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Start pulses in, finish pulses out
    input wire logic [NT-1:0] trigStart,
    output logic [NT-1:0] trigDone
);
    logic [NT-1:0] pipe_r [DLY];
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pipe_r <= '{default: '0};
        end else begin
            pipe_r[0] <= trigStart;
            for (int i = 1; i < DLY; i++) begin
                pipe_r[i] <= pipe_r[i-1];
            end
        end
    end
    // Finish only for a started function, never while idle
    assign trigDone = pipe_r[DLY-1];
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the register bit behaviour core
`timescale 1ns/1ps
module tb_top
    import mrb_pkg::*;
();
    typedef struct packed {
        logic [3:0] he;
        logic [3:0] ln;
        logic [2:0] sm;
        logic [2:0] rd;
        logic [3:0] eh;
        logic [3:0] el;
        logic [2:0] em;
    } mrb_row_t;
    logic mclk = 0, sys_rst = 1, rdHigh = 0, rdLow = 0, rdMax = 0;
    logic wrStb = 0, wrOverride = 0, wrLowPwr = 0;
    logic overrideWriteBit_r, lowPower_r;
    logic [4:0] strapPins = 5'h15, strapAddr_r;
    logic [3:0] highEvent = 4'h0, lowEventN = 4'hF;
    logic [3:0] latchHighBit_r, latchLowBit_r;
    logic [2:0] smState = 3'h0, latchMaxGroup_r;
    logic [1:0] wrTrig = 2'h0, trigDone, selfClearBit_r, trigStart_r;
    logic [7:0] wrProtData = 8'h00, wrRwData = 8'h00, protBits_r, rwBits_r;
    int failures = 0, nCompared = 0, k;
    mrb_row_t rows [8] = '{
        '{4'h1, 4'hF, 3'h6, 3'h0, 4'h1, 4'hF, 3'h6},
        '{4'h0, 4'hE, 3'h2, 3'h0, 4'h1, 4'hE, 3'h6},
        '{4'h0, 4'hF, 3'h3, 3'h7, 4'h0, 4'hF, 3'h3},
        '{4'h2, 4'hF, 3'h1, 3'h4, 4'h2, 4'hF, 3'h3},
        '{4'h0, 4'h7, 3'h1, 3'h2, 4'h2, 4'h7, 3'h3},
        '{4'h0, 4'hF, 3'h7, 3'h0, 4'h2, 4'h7, 3'h7},
        '{4'h0, 4'hF, 3'h0, 3'h1, 4'h2, 4'h7, 3'h0},
        '{4'h0, 4'hF, 3'h0, 3'h7, 4'h0, 4'hF, 3'h0}};
    mrb_reg_bits i_dut (.mclk, .sys_rst, .strapPins, .highEvent,
        .lowEventN, .smState, .trigDone, .rdHigh, .rdLow, .rdMax, .wrStb,
        .wrOverride, .wrTrig, .wrProtData, .wrRwData, .wrLowPwr,
        .strapAddr_r, .latchHighBit_r, .latchLowBit_r, .latchMaxGroup_r,
        .selfClearBit_r, .trigStart_r, .overrideWriteBit_r, .protBits_r,
        .rwBits_r, .lowPower_r);
    mrb_func_model #(.NT(NUM_TRIG), .DLY(6)) i_func (.mclk, .sys_rst,
        .trigStart(trigStart_r), .trigDone);
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic step;
        @(posedge mclk);
        #2;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobe stays up across back-to-back writes; caller drops it
    // Only defined fields are driven; reserved test bits never
    task automatic wr(input logic ovr, input logic lp,
            input logic [1:0] tg, input logic [7:0] pd, input logic [7:0] rw);
        wrStb = 1;
        wrOverride = ovr;
        wrLowPwr = lp;
        wrTrig = tg;
        wrProtData = pd;
        wrRwData = rw;
        step();
    endtask
    task automatic chk_rst(input logic [4:0] strap);
        chk({latchHighBit_r, latchLowBit_r}, {HIGH_RST, LOW_RST});
        chk({latchMaxGroup_r, strapAddr_r}, {MAX_RST, strap});
        chk(8'(selfClearBit_r), 8'(TRIG_RST));
        chk(8'(trigStart_r), 8'(TRIG_RST));
        chk({protBits_r}, PROT_RST);
        chk(rwBits_r, RW_RST);
        chk(8'({overrideWriteBit_r, lowPower_r}), 8'h00);
    endtask
    task automatic print_verdict;
        if (failures == 0 && nCompared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) step();
        chk_rst(5'h15);
        sys_rst = 0;
        strapPins = 5'h0A;
        step();
        chk(8'(strapAddr_r), 8'h15);
        foreach (rows[i]) begin
            {highEvent, lowEventN} = {rows[i].he, rows[i].ln};
            smState = rows[i].sm;
            {rdHigh, rdLow, rdMax} = rows[i].rd;
            step();
            chk(8'(latchHighBit_r), 8'(rows[i].eh));
            chk(8'(latchLowBit_r), 8'(rows[i].el));
            chk(8'(latchMaxGroup_r), 8'(rows[i].em));
        end
        {rdHigh, rdLow, rdMax} = 3'h0;
        wr(0, 0, 2'h0, 8'hA5, 8'h3C);
        chk(protBits_r, 8'h00);
        wr(1, 0, 2'h0, 8'hA5, 8'h3C);
        chk({protBits_r}, 8'h00);
        chk(8'(overrideWriteBit_r), 8'h01);
        wr(0, 0, 2'h0, 8'h5A, 8'hC3);
        chk({protBits_r}, 8'h5A);
        chk(8'(overrideWriteBit_r), 8'h00);
        chk(rwBits_r, 8'hC3);
        wr(0, 0, 2'h0, 8'hFF, 8'h00);
        chk(protBits_r, 8'h5A);
        wrStb = 0;
        {highEvent, lowEventN, smState} = {4'h8, 4'hB, 3'h5};
        step();
        {highEvent, lowEventN} = {4'h0, 4'hF};
        step();
        chk({latchHighBit_r, latchLowBit_r}, 8'h8B);
        wr(0, 1, 2'h0, 8'h00, 8'h00);
        chk({latchHighBit_r, latchLowBit_r}, {HIGH_RST, LOW_RST});
        chk({latchMaxGroup_r, protBits_r[4:0]}, {3'h5, 5'h1A});
        chk(8'(lowPower_r), 8'h01);
        highEvent = 4'h4;
        wr(0, 1, 2'h0, 8'h00, 8'h00);
        highEvent = 4'h0;
        chk(8'(latchHighBit_r), 8'h04);
        wr(0, 0, 2'h3, 8'h00, 8'h00);
        chk(8'({selfClearBit_r, trigStart_r}), 8'h0F);
        wrStb = 0;
        step();
        chk(8'({selfClearBit_r, trigStart_r}), 8'h0C);
        wr(0, 0, 2'h3, 8'h00, 8'h00);
        chk(8'(trigStart_r), 8'h00);
        wrStb = 0;
        for (k = 0; k < 20 && selfClearBit_r !== 2'h0; k++) step();
        chk(8'(selfClearBit_r), 8'h00);
        sys_rst = 1;
        step();
        chk_rst(5'h0A);
        print_verdict();
    end
    initial begin
        repeat (2000) @(posedge mclk);
        failures++;
        print_verdict();
    end
endmodule
